//--- logic/hpe_event_top.sv
// Hot-plug event signalling: slot flags, interrupt/wake/GPE routing, APB registers
//
// Overview of operation
// - Hot-plug interrupts need the interrupt enable bit
// - Each unmasked slot flag requests an interrupt
// - MSI enable and legacy disable choose delivery
// - Low power, enable off: wake message only
// - Low power, enable on: wake and interrupt
// - Masked event gives neither wake nor interrupt
// - Command done never causes a wake
// - GP event output is GPIO 7 alternate
// - GP mode port issues no interrupt or wake
// - GP mode port events assert GP output
// - Pin 7 shows GP event only if alternate
// - GP assertion sets that port's status bit
// - GP status sets only in GP mode
// - GP mode changes only the notification path
// - Non-hot-plug notifications ignore GP mode
// - Slot sensors arrive via I/O expander logic
// - Only downstream ports carry MSI capability
// - Outputs held low during reset; GPIO 7 pin not driven
// - Controller active only when hot-plug capable
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module hpe_event_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [hpe_pkg::AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Slot events from the I/O expander logic, one bit per flag
  input wire logic [hpe_pkg::NPORT-1:0][hpe_pkg::NEVT-1:0] slot_evt,
  // Notifications raised by non-hot-plug sources
  input wire logic [hpe_pkg::NPORT-1:0][2:0] other_src,
  // Notifications towards the root complex, per downstream port
  output logic [hpe_pkg::NPORT-1:0][2:0] notify,
  // General purpose event and GPIO 7 pin
  output logic gp_event_out,
  input wire logic gpio7_i,
  output logic gpio7_o,
  output logic gpio7_oe
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int NP = hpe_pkg::NPORT;
  localparam int NE = hpe_pkg::NEVT;
  localparam int AW = hpe_pkg::AW;

  hpe_pkg::hpe_slot_ctrl_s [NP-1:0] ctrl_q;
  hpe_pkg::hpe_notify_s [NP-1:0] notify_q;
  hpe_pkg::hpe_notify_s [NP-1:0] other_in;
  logic [NP-1:0][NE-1:0] flags_q;
  logic [NP-1:0][NE-1:0] flags_d;
  logic [NP-1:0][NE-1:0] new_evt;
  logic [NP-1:0][NE-1:0] live_evt;
  logic [NP-1:0][31:0] port_rdata;
  logic [NP-1:0] port_hit;
  logic [NP-1:0] hp_pend;
  logic [NP-1:0] hp_msi;
  logic [NP-1:0] hp_intx;
  logic [NP-1:0] hp_pme;
  logic [NP-1:0] gpe_set;
  logic [NP-1:0] gpe_ctl_q;
  logic [NP-1:0] gpe_sts_q;
  logic [NP-1:0] gpe_sts_d;
  logic [hpe_pkg::GLB_W-1:0] glb_ctrl_q;
  logic gp_out_q;
  logic gpio7_o_q;
  logic gpio7_oe_q;
  logic gpi_meta_q;
  logic gpi_sync_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rdata_mux;
  logic [31:0] port_rd_or;
  logic setup_ph;
  logic wr_fire;
  logic glb_hit;
  logic gctl_hit;
  logic gsts_hit;
  logic any_hit;
  logic sw_d3;
  logic gpo_alt;

  // Port match for one per-port register word
  function automatic logic port_reg_hit(input logic [hpe_pkg::AW-1:0] a, input int p,
                                        input logic [hpe_pkg::AW-1:0] sub);
    logic [hpe_pkg::AW-1:0] base;
    base = hpe_pkg::PORT_BASE_OFS + (hpe_pkg::PORT_STRIDE * AW'(p)) + sub;
    port_reg_hit = (a == base);
  endfunction

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Writes land only at the completing edge of the access phase
  // so a setup cycle that is abandoned never changes any register
  assign setup_ph = psel & ~penable;
  assign wr_fire = psel & penable & pwrite & pready_q;
  assign glb_hit = (paddr == hpe_pkg::GLB_CTRL_OFS);
  assign gctl_hit = (paddr == hpe_pkg::GPE_CTL_OFS);
  assign gsts_hit = (paddr == hpe_pkg::GPE_STS_OFS);
  assign any_hit = glb_hit | gctl_hit | gsts_hit | (|port_hit);
  assign sw_d3 = glb_ctrl_q[hpe_pkg::GLB_D3_BIT];
  assign gpo_alt = glb_ctrl_q[hpe_pkg::GLB_ALT_BIT];
  assign other_in = other_src;

  // Read data is the OR of all decoded words; unmapped reads return zero
  always_comb begin
    port_rd_or = 32'h0000_0000;
    for (int p = 0; p < NP; p++) begin
      port_rd_or = port_rd_or | port_rdata[p];
    end
  end

  assign rdata_mux = port_rd_or
    | (glb_hit ? {27'h000_0000, gpi_sync_q, glb_ctrl_q} : 32'h0000_0000)
    | (gctl_hit ? {27'h000_0000, gpe_ctl_q} : 32'h0000_0000)
    | (gsts_hit ? {27'h000_0000, gpe_sts_q} : 32'h0000_0000);

  // ---------------------------------------------------------------
  // Per-port hot-plug controller
  // ---------------------------------------------------------------
  for (genvar p = 0; p < NP; p++) begin : g_port
    logic ctl_hit;
    logic sts_hit;
    logic [NE-1:0] clr;

    assign ctl_hit = port_reg_hit(paddr, p, hpe_pkg::PORT_CTRL_OFS);
    assign sts_hit = port_reg_hit(paddr, p, hpe_pkg::PORT_STS_OFS);
    assign port_hit[p] = ctl_hit | sts_hit;
    assign clr = (wr_fire & sts_hit) ? pwdata[NE-1:0] : '0;

    // Flags only set while the port is hot-plug capable
    assign new_evt[p] = slot_evt[p] & ~flags_q[p] & {NE{ctrl_q[p].hotplug_capable_bit}};
    assign live_evt[p] = new_evt[p] & ~ctrl_q[p].evt_mask;
    // A same-cycle clear wins: an event on a flag that is already set is not a new event
    assign flags_d[p] = (flags_q[p] & ~clr) | new_evt[p];

    // Level pending request; GP mode removes it from the interrupt path
    assign hp_pend[p] = ctrl_q[p].hotplug_irq_enable & (|(flags_q[p] & ~ctrl_q[p].evt_mask))
                        & ~gpe_ctl_q[p];
    assign hp_msi[p] = ctrl_q[p].hotplug_irq_enable & ctrl_q[p].msi_enable & ~gpe_ctl_q[p]
                       & (|live_evt[p]);
    assign hp_intx[p] = hp_pend[p] & ~ctrl_q[p].msi_enable & ~ctrl_q[p].legacy_irq_disable;
    // Wake in low power, independent of the interrupt enable; never for command done
    assign hp_pme[p] = (ctrl_q[p].port_d3hot | sw_d3) & ~gpe_ctl_q[p]
                       & (|(live_evt[p] & ~(NE'(1) << hpe_pkg::EV_CMD_DONE)));
    assign gpe_set[p] = gpe_ctl_q[p] & (|live_evt[p]);

    assign port_rdata[p] = (ctl_hit ? {22'h00_0000, ctrl_q[p]} : 32'h0000_0000)
      | (sts_hit ? {23'h00_0000, hp_pend[p], 3'h0, flags_q[p]} : 32'h0000_0000);

    // Slot control and status storage
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        ctrl_q[p] <= hpe_pkg::SLOT_CTRL_RST;
        flags_q[p] <= hpe_pkg::FLAG_RST;
      end else begin
        if (wr_fire & ctl_hit) begin
          ctrl_q[p] <= pwdata[hpe_pkg::CTRL_W-1:0];
        end
        flags_q[p] <= flags_d[p];
      end
    end

    // Outside sources pass untouched by the GP mode setting; downstream only
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        notify_q[p] <= 3'h0;
      end else begin
        notify_q[p].msi <= hp_msi[p] | other_in[p].msi;
        notify_q[p].intx <= hp_intx[p] | other_in[p].intx;
        notify_q[p].pme <= hp_pme[p] | other_in[p].pme;
      end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    property p_irq_needs_enable;
      @(posedge clk) disable iff (sys_rst)
      notify_q[p].intx && !$past(other_in[p].intx) |-> $past(ctrl_q[p].hotplug_irq_enable);
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
      else $error("legacy interrupt without hot-plug enable");

    property p_legacy_off;
      @(posedge clk) disable iff (sys_rst)
      ctrl_q[p].legacy_irq_disable && !other_in[p].intx |=> !notify_q[p].intx;
    endproperty
    a_legacy_off: assert property (p_legacy_off)
      else $error("legacy interrupt while legacy delivery disabled");

    property p_masked_quiet;
      @(posedge clk) disable iff (sys_rst)
      (live_evt[p] == '0) && !other_in[p].msi && !other_in[p].pme |=> !notify_q[p].msi && !notify_q[p].pme;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
      else $error("masked event raised a notification");

    property p_cmd_no_wake;
      @(posedge clk) disable iff (sys_rst)
      (live_evt[p] == (NE'(1) << hpe_pkg::EV_CMD_DONE)) && !other_in[p].pme |=> !notify_q[p].pme;
    endproperty
    a_cmd_no_wake: assert property (p_cmd_no_wake)
      else $error("command done caused a wake");

    property p_wake_and_irq;
      @(posedge clk) disable iff (sys_rst)
      (|live_evt[p][3:0]) && ctrl_q[p].port_d3hot && ctrl_q[p].hotplug_irq_enable
      && ctrl_q[p].msi_enable && !gpe_ctl_q[p] |=> notify_q[p].pme && notify_q[p].msi;
    endproperty
    a_wake_and_irq: assert property (p_wake_and_irq)
      else $error("low-power enabled event missed wake or interrupt");

    property p_wake_only;
      @(posedge clk) disable iff (sys_rst)
      (|live_evt[p][3:0]) && sw_d3 && !ctrl_q[p].hotplug_irq_enable && !gpe_ctl_q[p]
      && !other_in[p].msi |=> notify_q[p].pme && !notify_q[p].msi;
    endproperty
    a_wake_only: assert property (p_wake_only)
      else $error("low-power event with enable off not a pure wake");

    property p_gp_mode_silent;
      @(posedge clk) disable iff (sys_rst)
      gpe_ctl_q[p] && !other_in[p].msi && !other_in[p].pme && !other_in[p].intx
      |=> !notify_q[p].msi && !notify_q[p].pme && !notify_q[p].intx;
    endproperty
    a_gp_mode_silent: assert property (p_gp_mode_silent)
      else $error("GP mode port raised a notification");

    property p_gp_sts_source;
      @(posedge clk) disable iff (sys_rst)
      $rose(gpe_sts_q[p]) |-> $past(gpe_ctl_q[p]) && $past(|live_evt[p]);
    endproperty
    a_gp_sts_source: assert property (p_gp_sts_source)
      else $error("GP status set outside GP mode");

    property p_gp_sts_set;
      @(posedge clk) disable iff (sys_rst)
      gpe_ctl_q[p] && (|live_evt[p]) |=> gpe_sts_q[p] && gp_out_q;
    endproperty
    a_gp_sts_set: assert property (p_gp_sts_set)
      else $error("GP event did not set status and output");

    property p_w1c;
      @(posedge clk) disable iff (sys_rst)
      wr_fire && sts_hit && pwdata[0] && !new_evt[p][0] |=> !flags_q[p][0];
    endproperty
    a_w1c: assert property (p_w1c)
      else $error("write of one did not clear flag");
  end

  // ---------------------------------------------------------------
  // Global control and GP event status
  // ---------------------------------------------------------------
  // Set beats a same-cycle write-one clear
  assign gpe_sts_d = (gpe_sts_q & ~((wr_fire & gsts_hit) ? pwdata[NP-1:0] : '0)) | gpe_set;

  // Software-owned configuration words
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      glb_ctrl_q <= hpe_pkg::GLB_CTRL_RST;
      gpe_ctl_q <= hpe_pkg::GPE_RST;
    end else begin
      if (wr_fire & glb_hit) begin
        glb_ctrl_q <= pwdata[hpe_pkg::GLB_W-1:0];
      end
      if (wr_fire & gctl_hit) begin
        gpe_ctl_q <= pwdata[NP-1:0];
      end
    end
  end

  // GP status and shared output; output follows status with no extra lag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpe_sts_q <= hpe_pkg::GPE_RST;
      gp_out_q <= 1'b0;
    end else begin
      gpe_sts_q <= gpe_sts_d;
      gp_out_q <= |gpe_sts_d;
    end
  end

  // ---------------------------------------------------------------
  // GPIO 7 pin
  // ---------------------------------------------------------------
  // Pin is released during reset; alternate mode drives the GP level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpio7_o_q <= 1'b0;
      gpio7_oe_q <= 1'b0;
    end else begin
      gpio7_o_q <= gpo_alt ? (|gpe_sts_d) : glb_ctrl_q[hpe_pkg::GLB_GPO_BIT];
      gpio7_oe_q <= gpo_alt | glb_ctrl_q[hpe_pkg::GLB_GPOE_BIT];
    end
  end

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpi_meta_q <= 1'b0;
      gpi_sync_q <= 1'b0;
    end else begin
      gpi_meta_q <= gpio7_i;
      gpi_sync_q <= gpi_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // APB response
  // ---------------------------------------------------------------
  // One wait-free access phase: data and error are captured at setup
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= hpe_pkg::RDATA_RST;
    end else begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        pslverr_q <= ~any_hit;
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign notify = notify_q;
  assign gp_event_out = gp_out_q;
  assign gpio7_o = gpio7_o_q;
  assign gpio7_oe = gpio7_oe_q;

  // ---------------------------------------------------------------
  // Shared-pin checks
  // ---------------------------------------------------------------
  property p_pin_gpio_mode;
    @(posedge clk) disable iff (sys_rst)
    !gpo_alt |=> gpio7_o_q == $past(glb_ctrl_q[hpe_pkg::GLB_GPO_BIT])
                 && gpio7_oe_q == $past(glb_ctrl_q[hpe_pkg::GLB_GPOE_BIT]);
  endproperty
  a_pin_gpio_mode: assert property (p_pin_gpio_mode)
    else $error("GPIO 7 lost ordinary behaviour");

  property p_gp_hold;
    @(posedge clk) disable iff (sys_rst)
    gp_out_q == (gpe_sts_q != '0);
  endproperty
  a_gp_hold: assert property (p_gp_hold)
    else $error("GP output not tracking status");

endmodule
`default_nettype wire

//--- logic/hpe_pkg.sv
// Package: constants and carrier types for the hot-plug event signalling block
`default_nettype none
package hpe_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NPORT = 5; // Downstream ports 1..5 map to index 0..4
  localparam int NEVT = 5;
  localparam int AW = 12;

  // ---------------------------------------------------------------
  // Slot status flag positions
  // ---------------------------------------------------------------
  localparam int EV_BUTTON = 0;
  localparam int EV_PFAULT = 1;
  localparam int EV_LATCH = 2;
  localparam int EV_PRESENCE = 3;
  localparam int EV_CMD_DONE = 4;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] GLB_CTRL_OFS = 12'h000;
  localparam logic [AW-1:0] GPE_CTL_OFS = 12'h004;
  localparam logic [AW-1:0] GPE_STS_OFS = 12'h008;
  localparam logic [AW-1:0] PORT_BASE_OFS = 12'h010;
  localparam logic [AW-1:0] PORT_STRIDE = 12'h008;
  localparam logic [AW-1:0] PORT_CTRL_OFS = 12'h000;
  localparam logic [AW-1:0] PORT_STS_OFS = 12'h004;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GLB_D3_BIT = 0;
  localparam int GLB_ALT_BIT = 1;
  localparam int GLB_GPO_BIT = 2;
  localparam int GLB_GPOE_BIT = 3;
  localparam int GLB_GPI_BIT = 4;
  localparam int GLB_W = 4;
  localparam int STS_PEND_BIT = 8;
  localparam int CTRL_W = 10;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Per-port slot control, laid out as bits [9:0] of the control word
  typedef struct packed {
    logic hotplug_capable_bit;
    logic port_d3hot;
    logic legacy_irq_disable;
    logic msi_enable;
    logic hotplug_irq_enable;
    logic [NEVT-1:0] evt_mask;
  } hpe_slot_ctrl_s;

  // Notification group: msi and pme are pulses, intx is a level
  typedef struct packed {
    logic msi;
    logic intx;
    logic pme;
  } hpe_notify_s;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CTRL_W-1:0] SLOT_CTRL_RST = 10'h000;
  localparam logic [GLB_W-1:0] GLB_CTRL_RST = 4'h0;
  localparam logic [NPORT-1:0] GPE_RST = 5'h00;
  localparam logic [NEVT-1:0] FLAG_RST = 5'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage
`default_nettype wire

//--- verif/hpe_rc_model.sv
// Root complex side model: counts each new notification per port
`timescale 1ns/10ps
`default_nettype none
module hpe_rc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Notifications from the switch
  input wire logic [hpe_pkg::NPORT-1:0][2:0] notify,
  // Rising edges seen, per port and per kind {msi,intx,pme}
  output logic [hpe_pkg::NPORT-1:0][2:0][7:0] seen
);
  // ---------------------------------------------------------------
  // Edge counting
  // ---------------------------------------------------------------
  logic [hpe_pkg::NPORT-1:0][2:0] prev_q;

  // Counting edges treats a pulse and a held level alike, so the bench
  // need not know how long a source was held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= '0;
      seen <= '0;
    end else begin
      prev_q <= notify;
      for (int p = 0; p < hpe_pkg::NPORT; p++) begin
        for (int b = 0; b < 3; b++) begin
          if (notify[p][b] && !prev_q[p][b]) begin
            seen[p][b] <= seen[p][b] + 8'h01;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/test_hotplug_event_signalling.sv
// Testbench: APB register access and hot-plug event routing checks
`timescale 1ns/10ps
`default_nettype none
module test_hotplug_event_signalling;
  logic clk, sys_rst, psel, penable, pwrite, pin_ext, pready, pslverr;
  logic gp_event_out, gpio7_i, gpio7_o, gpio7_oe;
  logic [hpe_pkg::AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [hpe_pkg::NPORT-1:0][hpe_pkg::NEVT-1:0] slot_evt;
  logic [hpe_pkg::NPORT-1:0][2:0] other_src, notify;
  logic [hpe_pkg::NPORT-1:0][2:0][7:0] seen;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  // ---------------------------------------------------------------
  // Clock, pin and instances
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The pin level follows whoever drives it
  assign gpio7_i = gpio7_oe ? gpio7_o : pin_ext;

  hpe_event_top u_hpe_event_top (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slot_evt(slot_evt), .other_src(other_src), .notify(notify),
    .gp_event_out(gp_event_out), .gpio7_i(gpio7_i), .gpio7_o(gpio7_o), .gpio7_oe(gpio7_oe));
  hpe_rc_model u_hpe_rc_model (.clk(clk), .sys_rst(sys_rst), .notify(notify), .seen(seen));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready with no assumed latency
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdata & msk, exp);
  endtask

  function automatic logic [11:0] pa(input int p, input logic sts);
    return hpe_pkg::PORT_BASE_OFS + 12'(p) * hpe_pkg::PORT_STRIDE +
      (sts ? hpe_pkg::PORT_STS_OFS : hpe_pkg::PORT_CTRL_OFS);
  endfunction

  // Raises one slot event for a single cycle, then lets notifications settle
  task automatic evt(input int p, input int b);
    @(posedge clk);
    slot_evt[p][b] <= 1'b1;
    @(posedge clk);
    slot_evt[p][b] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic seen_chk(input int p, input logic [7:0] m, input logic [7:0] i, input logic [7:0] w);
    chk({8'h00, seen[p]}, {8'h00, m, i, w});
  endtask

  // Cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, pin_ext} = 4'h0;
    paddr = '0;
    pwdata = '0;
    slot_evt = '0;
    other_src = '0;
    repeat (2) @(posedge clk);
    chk({14'h0000, gpio7_oe, gpio7_o, gp_event_out, notify}, 32'h0000_0000);
    sys_rst <= 1'b0;
    // Reset values and an unmapped address
    rd(hpe_pkg::GLB_CTRL_OFS, 32'h0000_0000, 32'h0000_000F);
    rd(hpe_pkg::GPE_CTL_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(hpe_pkg::GPE_STS_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(pa(0, 1'b0), 32'h0000_0000, 32'hFFFF_FFFF);
    rd(pa(0, 1'b1), 32'h0000_0000, 32'hFFFF_FFFF);
    rd(12'hFF0, 32'h0000_0000, 32'hFFFF_FFFF);
    chk({31'h0, pslverr}, 32'h0000_0001);
    // A port that is not hot-plug capable ignores its events
    wr(pa(0, 1'b0), 32'h0000_0060);
    evt(0, 0);
    rd(pa(0, 1'b1), 32'h0000_0000, 32'h0000_001F);
    seen_chk(0, 8'h00, 8'h00, 8'h00);
    // Every slot flag raises its own message interrupt
    wr(pa(0, 1'b0), 32'h0000_0260);
    for (int b = 0; b < hpe_pkg::NEVT; b++) begin
      evt(0, b);
      seen_chk(0, 8'(b + 1), 8'h00, 8'h00);
    end
    rd(pa(0, 1'b1), 32'h0000_001F, 32'h0000_001F);
    wr(pa(0, 1'b1), 32'h0000_0000);
    rd(pa(0, 1'b1), 32'h0000_001F, 32'h0000_001F);
    wr(pa(0, 1'b1), 32'h0000_0001);
    rd(pa(0, 1'b1), 32'h0000_001E, 32'h0000_001F);
    wr(pa(0, 1'b1), 32'h0000_001E);
    // Interrupt enable off: no interrupt
    wr(pa(0, 1'b0), 32'h0000_0240);
    evt(0, 1);
    seen_chk(0, 8'h05, 8'h00, 8'h00);
    wr(pa(0, 1'b1), 32'h0000_001F);
    // Legacy level when messages are off, none when legacy is disabled
    wr(pa(0, 1'b0), 32'h0000_0220);
    evt(0, 2);
    chk({31'h0, notify[0][1]}, 32'h0000_0001);
    wr(pa(0, 1'b1), 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk({31'h0, notify[0][1]}, 32'h0000_0000);
    wr(pa(0, 1'b0), 32'h0000_02A0);
    evt(0, 2);
    seen_chk(0, 8'h05, 8'h01, 8'h00);
    rd(pa(0, 1'b1), 32'h0000_0104, 32'h0000_011F);
    wr(pa(0, 1'b1), 32'h0000_001F);
    // Masked event in low power: flag only
    wr(pa(0, 1'b0), 32'h0000_0368);
    evt(0, 3);
    seen_chk(0, 8'h05, 8'h01, 8'h00);
    rd(pa(0, 1'b1), 32'h0000_0008, 32'h0000_001F);
    wr(pa(0, 1'b1), 32'h0000_001F);
    // Low power: wake alone, wake with interrupt, never for command done
    wr(pa(0, 1'b0), 32'h0000_0340);
    evt(0, 0);
    seen_chk(0, 8'h05, 8'h01, 8'h01);
    wr(pa(0, 1'b0), 32'h0000_0360);
    evt(0, 1);
    seen_chk(0, 8'h06, 8'h01, 8'h02);
    evt(0, 4);
    seen_chk(0, 8'h07, 8'h01, 8'h02);
    wr(pa(0, 1'b1), 32'h0000_001F);
    wr(hpe_pkg::GLB_CTRL_OFS, 32'h0000_0001);
    wr(pa(0, 1'b0), 32'h0000_0260);
    evt(0, 2);
    seen_chk(0, 8'h08, 8'h01, 8'h03);
    wr(hpe_pkg::GLB_CTRL_OFS, 32'h0000_0000);
    // General purpose event mode on port 1
    wr(pa(1, 1'b0), 32'h0000_0360);
    wr(hpe_pkg::GPE_CTL_OFS, 32'h0000_0002);
    evt(1, 0);
    seen_chk(1, 8'h00, 8'h00, 8'h00);
    chk({31'h0, gp_event_out}, 32'h0000_0001);
    chk({31'h0, gpio7_o}, 32'h0000_0000);
    rd(hpe_pkg::GPE_STS_OFS, 32'h0000_0002, 32'h0000_001F);
    rd(pa(1, 1'b1), 32'h0000_0001, 32'h0000_001F);
    wr(hpe_pkg::GLB_CTRL_OFS, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk({31'h0, gpio7_o}, 32'h0000_0001);
    // Other sources still notify on a port in this mode
    @(posedge clk);
    other_src[1] <= 3'b111;
    repeat (3) @(posedge clk);
    other_src[1] <= 3'b000;
    repeat (4) @(posedge clk);
    seen_chk(1, 8'h01, 8'h01, 8'h01);
    wr(hpe_pkg::GPE_STS_OFS, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({31'h0, gp_event_out}, 32'h0000_0001);
    wr(hpe_pkg::GPE_STS_OFS, 32'h0000_0002);
    repeat (3) @(posedge clk);
    chk({31'h0, gp_event_out}, 32'h0000_0000);
    // Ordinary GPIO behaviour and the synchronised pin input
    wr(hpe_pkg::GLB_CTRL_OFS, 32'h0000_0004);
    repeat (4) @(posedge clk);
    rd(hpe_pkg::GLB_CTRL_OFS, 32'h0000_0004, 32'h0000_001F);
    wr(hpe_pkg::GLB_CTRL_OFS, 32'h0000_000C);
    repeat (4) @(posedge clk);
    chk({30'h0, gpio7_oe, gpio7_o}, 32'h0000_0003);
    rd(hpe_pkg::GLB_CTRL_OFS, 32'h0000_001C, 32'h0000_001F);
    summarize();
  end
endmodule
`default_nettype wire
